// >>> pkg/ccp_regs.svh
// Register offsets, field positions, reset values and counts of the capture/compare unit
`ifndef CCP_REGS_SVH
`define CCP_REGS_SVH
`define CCP_OFF_CTRL 8'h00
`define CCP_OFF_PRESC 8'h04
`define CCP_OFF_TIMER 8'h08
`define CCP_OFF_RELOAD 8'h0C
`define CCP_OFF_CMPA 8'h10
`define CCP_OFF_CAPA 8'h20
`define CCP_OFF_CAPB 8'h24
`define CCP_OFF_EVCNT 8'h28
`define CCP_OFF_FLAGS 8'h2C
`define CCP_OFF_IEN 8'h30
`define CCP_OFF_STAT 8'h34
`define CCP_F_MODE 0
`define CCP_F_DOWN 2
`define CCP_F_RUN 3
`define CCP_F_NARROW 4
`define CCP_F_ALT 5
`define CCP_F_PLLDIV 8
`define CCP_F_CHEN 12
`define CCP_F_POL 16
`define CCP_F_HALT 20
`define CCP_F_EDGE 24
`define CCP_F_FILT 26
`define CCP_F_EVB 4
`define CCP_RST_CTRL 32'h0000_0000
`define CCP_RST_PRESC 10'h3FF
`define CCP_RST_WORD 16'h0000
`define CCP_PRESC_W 10
`define CCP_FILT_LEN 4
`define CCP_PLL_MULT 32
`define CCP_PLL_LOCK_REFS 6'h20
`endif

// >>> pkg/ccp_pkg.sv
// Types shared by the capture/compare unit modules
package ccp_pkg;
  typedef logic [15:0] ccp_word_t;
  typedef enum logic [1:0] {CCP_BASIC = 2'b00, CCP_ASYM = 2'b01, CCP_SYM = 2'b10} ccp_mode_t;
  typedef enum logic [1:0] {CCP_PLL_OFF = 2'b00, CCP_PLL_LOCK = 2'b01, CCP_PLL_RUN = 2'b10} ccp_pll_t;
endpackage

// >>> pkg/ccp_cap_if.sv
// Timer value out to a capture channel, capture event and value back
interface ccp_cap_if;
  logic [15:0] timer;
  logic evt;
  logic [15:0] val;
  modport cap (input timer, output evt, output val);
  modport host (output timer, input evt, input val);
endinterface

// >>> src/ccp_prescale.sv
// Reloadable free-running prescaler giving one tick per division period
`include "ccp_regs.svh"
module ccp_prescale #(
  parameter int W = `CCP_PRESC_W
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic en, // Unit clock enable
  input wire logic [W-1:0] reload, // Reload value, ratio 2**W - reload
  output logic tick // Terminal event
);
  import ccp_pkg::*;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Terminal at all ones, then reload
  assign tick = en & (&cnt_r);
  assign cnt_nxt = tick ? reload : cnt_r + {{(W-1){1'b0}}, 1'b1};

  // Count on each unit clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '1;
    end else if (en) begin
      cnt_r <= cnt_nxt; // [R02]
    end
  end

  count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !en |=> $stable(cnt_r)) else $error("prescaler moved without enable"); // [R02]
endmodule

// >>> src/ccp_capture.sv
// One capture input: noise filter, edge select, event counter, capture register
`include "ccp_regs.svh"
module ccp_capture #(
  parameter int FLEN = `CCP_FILT_LEN,
  parameter int CW = 4
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic pin, // Capture input pin
  input wire logic edge_fall, // 1 falling edge, 0 rising edge
  input wire logic filt_en, // Noise filter enable
  input wire logic [CW-1:0] evt_limit, // Events skipped before a capture
  ccp_cap_if.cap cif // Timer in, capture out
);
  import ccp_pkg::*;
  logic [FLEN-1:0] samp_r;
  logic lvl_r;
  logic prev_r;
  logic [CW-1:0] ev_r;
  logic evt_r;
  ccp_word_t val_r;
  logic lvl_nxt;
  logic edge_hit;
  logic ev_done;

  // Filtered level moves only after FLEN equal samples
  assign lvl_nxt = !filt_en ? pin : (&samp_r) ? 1'b1 : (~|samp_r) ? 1'b0 : lvl_r; // [R17]
  assign edge_hit = (lvl_r != prev_r) & (lvl_r ^ edge_fall); // [R16]
  assign ev_done = edge_hit & (ev_r == evt_limit); // [R18]
  assign cif.evt = evt_r;
  assign cif.val = val_r;

  // Sampling and level tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_r <= '0;
      lvl_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      samp_r <= {samp_r[FLEN-2:0], pin};
      lvl_r <= lvl_nxt;
      prev_r <= lvl_r;
    end
  end

  // Event counting and capture, always active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_r <= '0;
      evt_r <= 1'b0;
      val_r <= '0;
    end else begin
      evt_r <= ev_done;
      if (edge_hit) begin
        ev_r <= ev_done ? '0 : ev_r + {{(CW-1){1'b0}}, 1'b1}; // [R18]
      end
      if (ev_done) begin
        val_r <= cif.timer; // [R15] [R04]
      end
    end
  end

  filt_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    filt_en && $past(filt_en) && (lvl_r != $past(lvl_r)) |-> (&$past(samp_r)) || (~|$past(samp_r)))
    else $error("filtered level changed without equal samples"); // [R17]
  cap_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    ev_done |=> evt_r && (val_r == $past(cif.timer)))
    else $error("capture value not taken from timer"); // [R15]
  cap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ev_done |=> $stable(val_r)) else $error("capture register changed without event"); // [R18]
endmodule

// >>> src/ccp_unit.sv
// Capture/compare/PWM unit with APB register access
//
// Decided for this implementation: the register addresses and the APB slave port.
`include "ccp_regs.svh"
// Functional notes
// R01: 16-bit timer reloads reload value on overflow
// R02: 10-bit prescaler, division ratio 1 to 1024
// R03: Four compare channels with selectable output polarity
// R04: Two capture inputs, own counter and filter
// R05: Seven flags share one interrupt request
// R06: Byte writes to 16-bit registers via shadow
// R07: Basic mode peripheral clock, PWM modes PLL
// R08: PLL multiplies reference by 32
// R09: PLL reference is clock divided by N+1
// R10: Direction bit sets count way, reverses live
// R11: Timer readable and writable at any time
// R12: Overflow flag set on every reload
// R13: Timer may run as 8-bit counter
// R14: Enabled compare channel flags on timer match
// R15: Capture copies timer into capture register
// R16: Rising or falling capture edge per input
// R17: Filter needs four equal samples per edge
// R18: Event counter delays capture by N events
// R19: Asymmetrical PWM counts down only
// R20: Symmetrical PWM counts up and down alternately
// R21: Pin holds halt level until compare event; in asymmetrical PWM the code also sets the state to 1 at a timer wrap
// R22: Alternating mode gates pairs A/B, C/D alternately
// R23: Timer steps once per prescaler terminal event
module ccp_unit (
  input wire logic pclk, // Clock, 200 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic [1:0] cap_in, // Capture pins
  output logic [3:0] cmp_out, // Compare/PWM pins
  output logic [3:0] cmp_oe, // Compare pin drive enables
  output logic irq // Common interrupt request
);
  import ccp_pkg::*;
  logic [31:0] ctrl_r;
  logic [`CCP_PRESC_W-1:0] presc_r;
  ccp_word_t timer_r;
  ccp_word_t reload_r;
  ccp_word_t cmp_r [4];
  ccp_word_t cap_val [2];
  logic [1:0] cap_evt;
  logic [7:0] evcnt_r;
  logic [6:0] flags_r;
  logic [6:0] ien_r;
  logic [7:0] shadow_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic sym_down_r;
  logic alt_phase_r;
  logic [3:0] st_r;
  logic [3:0] out_r;
  logic [3:0] refdiv_r;
  logic [5:0] lock_cnt_r;
  ccp_pll_t pll_st_r;
  ccp_pll_t pll_nxt;

  // 16-bit write with byte lanes; a low-byte-only write only fills the shadow
  function automatic ccp_word_t wr16(input ccp_word_t old_v, input logic [31:0] d,
                                     input logic [3:0] s, input logic [7:0] sh);
    wr16 = old_v;
    if (s[1]) begin
      wr16 = {d[15:8], s[0] ? d[7:0] : sh}; // [R06]
    end
  endfunction

  // Byte-lane merge for plain control words
  function automatic logic [31:0] wr32(input logic [31:0] old_v, input logic [31:0] d, input logic [3:0] s);
    wr32 = old_v;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        wr32[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction

  // Timer equality, low byte only in 8-bit mode
  function automatic logic match16(input ccp_word_t a, input ccp_word_t b, input logic narrow);
    match16 = narrow ? (a[7:0] == b[7:0]) : (a == b);
  endfunction

  // APB decode
  logic wr_acc;
  logic rd_setup;
  logic sel_ctrl;
  logic sel_presc;
  logic sel_timer;
  logic sel_reload;
  logic sel_evcnt;
  logic sel_flags;
  logic sel_ien;
  logic [3:0] sel_cmp;
  logic mapped;
  logic low_only;
  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign sel_ctrl = paddr == `CCP_OFF_CTRL;
  assign sel_presc = paddr == `CCP_OFF_PRESC;
  assign sel_timer = paddr == `CCP_OFF_TIMER;
  assign sel_reload = paddr == `CCP_OFF_RELOAD;
  assign sel_evcnt = paddr == `CCP_OFF_EVCNT;
  assign sel_flags = paddr == `CCP_OFF_FLAGS;
  assign sel_ien = paddr == `CCP_OFF_IEN;
  assign mapped = sel_ctrl | sel_presc | sel_timer | sel_reload | (|sel_cmp) | sel_evcnt | sel_flags | sel_ien
                | (paddr == `CCP_OFF_CAPA) | (paddr == `CCP_OFF_CAPB) | (paddr == `CCP_OFF_STAT);
  assign low_only = pstrb[1:0] == 2'b01;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata_r;

  // Control fields
  ccp_mode_t mode;
  logic is_basic;
  logic is_asym;
  logic is_sym;
  logic narrow;
  logic [3:0] pll_div;
  logic [3:0] chen;
  logic [3:0] pol;
  logic [3:0] halt;
  assign mode = ccp_mode_t'(ctrl_r[`CCP_F_MODE +: 2]);
  assign is_asym = mode == CCP_ASYM;
  assign is_sym = mode == CCP_SYM;
  assign is_basic = ~is_asym & ~is_sym;
  assign narrow = ctrl_r[`CCP_F_NARROW];
  assign pll_div = ctrl_r[`CCP_F_PLLDIV +: 4];
  assign chen = ctrl_r[`CCP_F_CHEN +: 4];
  assign pol = ctrl_r[`CCP_F_POL +: 4];
  assign halt = ctrl_r[`CCP_F_HALT +: 4];
  assign cmp_oe = chen; // pin connected to compare logic only while enabled

  // PLL reference divider and lock sequencing
  logic ref_tick;
  logic unit_en;
  assign ref_tick = refdiv_r == pll_div; // [R09]
  assign unit_en = is_basic | (pll_st_r == CCP_PLL_RUN); // [R07]

  always_comb begin
    pll_nxt = pll_st_r;
    case (pll_st_r)
      CCP_PLL_OFF: begin
        if (!is_basic) pll_nxt = CCP_PLL_LOCK;
      end
      CCP_PLL_LOCK: begin
        if (is_basic) pll_nxt = CCP_PLL_OFF;
        else if (ref_tick && lock_cnt_r == `CCP_PLL_LOCK_REFS - 6'h01) pll_nxt = CCP_PLL_RUN; // [R08]
      end
      CCP_PLL_RUN: begin
        if (is_basic) pll_nxt = CCP_PLL_OFF;
      end
      default: pll_nxt = CCP_PLL_OFF;
    endcase
  end

  // PLL state and counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_st_r <= CCP_PLL_OFF;
      refdiv_r <= 4'h0;
      lock_cnt_r <= 6'h00;
    end else begin
      pll_st_r <= pll_nxt;
      refdiv_r <= ref_tick ? 4'h0 : refdiv_r + 4'h1; // [R09]
      lock_cnt_r <= (pll_st_r == CCP_PLL_LOCK) ? lock_cnt_r + {5'h00, ref_tick} : 6'h00;
    end
  end

  // Prescaler
  logic presc_tick;
  ccp_prescale #(.W(`CCP_PRESC_W)) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .en(unit_en),
    .reload(presc_r),
    .tick(presc_tick)
  );

  // Timer stepping, direction and wrap
  logic tmr_tick;
  logic cnt_down;
  logic at_floor;
  logic at_ceil;
  logic sym_turn;
  logic tmr_wrap;
  logic step_down;
  logic tmr_wr;
  ccp_word_t reload_eff;
  ccp_word_t top_val;
  ccp_word_t timer_step;
  ccp_word_t timer_nxt;
  assign tmr_tick = presc_tick & ctrl_r[`CCP_F_RUN]; // [R23]
  assign cnt_down = is_asym | (is_sym ? sym_down_r : ctrl_r[`CCP_F_DOWN]); // [R10] [R19]
  assign reload_eff = narrow ? {8'h00, reload_r[7:0]} : reload_r; // [R13]
  assign top_val = narrow ? 16'h00FF : 16'hFFFF;
  assign at_floor = timer_r == 16'h0000;
  assign at_ceil = is_sym ? (timer_r >= reload_eff) : (timer_r == top_val);
  assign sym_turn = tmr_tick & is_sym & (cnt_down ? at_floor : at_ceil); // [R20]
  assign tmr_wrap = tmr_tick & (is_sym ? (cnt_down & at_floor) : (cnt_down ? at_floor : at_ceil)); // [R12]
  assign step_down = cnt_down ^ sym_turn;
  assign timer_step = step_down ? timer_r - 16'h0001 : timer_r + 16'h0001;
  assign tmr_wr = wr_acc & sel_timer & pstrb[1];
  assign timer_nxt = tmr_wr ? wr16(timer_r, pwdata, pstrb, shadow_r)
                   : (tmr_wrap & ~is_sym) ? reload_eff
                   : tmr_tick ? timer_step : timer_r; // [R01] [R11]

  // Timer and symmetric direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_r <= `CCP_RST_WORD;
      sym_down_r <= 1'b0;
      alt_phase_r <= 1'b0;
    end else begin
      timer_r <= timer_nxt; // [R11]
      sym_down_r <= is_sym ? (sym_down_r ^ sym_turn) : 1'b0; // [R20]
      alt_phase_r <= alt_phase_r ^ tmr_wrap; // [R22]
    end
  end

  // Capture channels
  for (genvar g = 0; g < 2; g++) begin : gen_cap
    ccp_cap_if cif ();
    assign cif.timer = timer_r;
    assign cap_evt[g] = cif.evt;
    assign cap_val[g] = cif.val;
    ccp_capture #(.FLEN(`CCP_FILT_LEN), .CW(4)) u_cap (
      .pclk(pclk),
      .presetn(presetn),
      .pin(cap_in[g]),
      .edge_fall(ctrl_r[`CCP_F_EDGE + g]),
      .filt_en(ctrl_r[`CCP_F_FILT + g]),
      .evt_limit(evcnt_r[g*`CCP_F_EVB +: 4]),
      .cif(cif)
    ); // [R04]
  end

  // Compare channels: match, waveform state, alternating gate, polarity
  logic [3:0] cmp_hit;
  logic [3:0] gate_off;
  for (genvar g = 0; g < 4; g++) begin : gen_cmp
    assign sel_cmp[g] = paddr == (`CCP_OFF_CMPA | 8'(g << 2));
    assign cmp_hit[g] = tmr_tick & chen[g] & match16(timer_r, cmp_r[g], narrow); // [R14]
    assign gate_off[g] = is_asym & ctrl_r[`CCP_F_ALT] & (alt_phase_r ^ 1'(g % 2)); // [R22]
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cmp_r[g] <= `CCP_RST_WORD;
        st_r[g] <= 1'b0;
        out_r[g] <= 1'b0;
      end else begin
        if (wr_acc && sel_cmp[g]) cmp_r[g] <= wr16(cmp_r[g], pwdata, pstrb, shadow_r); // [R06]
        if (!chen[g]) st_r[g] <= halt[g]; // [R21]
        else if (cmp_hit[g]) st_r[g] <= is_asym ? 1'b0 : is_sym ? ~cnt_down : ~st_r[g]; // [R20] [R21]
        else if (is_asym && tmr_wrap) st_r[g] <= 1'b1;
        out_r[g] <= (st_r[g] & ~gate_off[g]) ^ pol[g]; // [R03]
      end
    end
  end
  assign cmp_out = out_r;

  // Flags: hardware set wins over write-one clear
  logic [6:0] flag_set;
  logic [6:0] flag_clr;
  assign flag_set = {cmp_hit, cap_evt, tmr_wrap}; // [R05]
  assign flag_clr = (wr_acc && sel_flags && pstrb[0]) ? pwdata[6:0] : 7'h00;
  assign irq = irq_r;

  // Read data selection
  logic [31:0] rd_mux;
  assign rd_mux = sel_ctrl ? ctrl_r
                : sel_presc ? {22'h000000, presc_r}
                : sel_timer ? {16'h0000, timer_r}
                : sel_reload ? {16'h0000, reload_r}
                : (|sel_cmp) ? {16'h0000, cmp_r[paddr[3:2]]}
                : (paddr == `CCP_OFF_CAPA) ? {16'h0000, cap_val[0]}
                : (paddr == `CCP_OFF_CAPB) ? {16'h0000, cap_val[1]}
                : sel_evcnt ? {24'h000000, evcnt_r}
                : sel_flags ? {25'h0000000, flags_r}
                : sel_ien ? {25'h0000000, ien_r}
                : (paddr == `CCP_OFF_STAT) ? {27'h0000000, pll_st_r, alt_phase_r, cnt_down, tmr_tick}
                : 32'h0000_0000;

  // Prescaler word after byte-lane merge
  logic [31:0] presc_wr;
  assign presc_wr = wr32({22'h000000, presc_r}, pwdata, pstrb);

  // Register writes, flags, read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `CCP_RST_CTRL;
      presc_r <= `CCP_RST_PRESC;
      reload_r <= `CCP_RST_WORD;
      evcnt_r <= 8'h00;
      ien_r <= 7'h00;
      flags_r <= 7'h00;
      shadow_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
    end else begin
      if (wr_acc && sel_ctrl) ctrl_r <= wr32(ctrl_r, pwdata, pstrb);
      if (wr_acc && sel_presc) presc_r <= presc_wr[`CCP_PRESC_W-1:0];
      if (wr_acc && sel_reload) reload_r <= wr16(reload_r, pwdata, pstrb, shadow_r); // [R06]
      if (wr_acc && sel_evcnt && pstrb[0]) evcnt_r <= pwdata[7:0];
      if (wr_acc && sel_ien && pstrb[0]) ien_r <= pwdata[6:0];
      if (wr_acc && low_only) shadow_r <= pwdata[7:0]; // [R06]
      flags_r <= (flags_r & ~flag_clr) | flag_set; // [R12] [R14]
      irq_r <= |(flags_r & ien_r); // [R05]
      if (rd_setup) rdata_r <= rd_mux;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  wrap_reload_a: assert property (tmr_wrap && !is_sym && !tmr_wr |=> timer_r == $past(reload_eff))
    else $error("timer did not reload on wrap"); // [R01]
  step_tick_a: assert property (!tmr_tick && !tmr_wr |=> $stable(timer_r))
    else $error("timer moved without prescaler event"); // [R23]
  ovf_flag_a: assert property (tmr_wrap |=> flags_r[0] ##1 (irq_r || !ien_r[0]))
    else $error("overflow flag or request missing"); // [R12]
  cmp_flag_a: assert property (tmr_tick && chen[0] && match16(timer_r, cmp_r[0], narrow) |=> flags_r[3])
    else $error("compare flag not set on match"); // [R14]
  asym_down_a: assert property (is_asym && tmr_tick && !at_floor && !tmr_wr |=> timer_r == $past(timer_r) - 16'h0001)
    else $error("asymmetric mode not counting down"); // [R19]
  up_count_a: assert property (is_basic && !cnt_down && tmr_tick && !at_ceil && !tmr_wr
    |=> timer_r == $past(timer_r) + 16'h0001) else $error("basic up count wrong"); // [R10]
  sym_turn_a: assert property (is_sym && cnt_down && tmr_tick && at_floor |=> !sym_down_r || !is_sym)
    else $error("symmetric count did not turn at zero"); // [R20]
  halt_hold_a: assert property ((!chen[0] && $stable(ctrl_r))[*3] |-> cmp_out[0] == (halt[0] ^ pol[0]))
    else $error("disabled channel not at halt level"); // [R21]
  pll_gate_a: assert property (!is_basic && pll_st_r != CCP_PLL_RUN |-> !presc_tick)
    else $error("unit clock ran before PLL lock"); // [R07]
  ref_div_a: assert property (ref_tick && pll_div == 4'h3
    |=> (!ref_tick || pll_div != 4'h3)[*3] ##1 (ref_tick || pll_div != 4'h3))
    else $error("reference divider ratio wrong"); // [R09]
  narrow_wrap_a: assert property (is_basic && narrow && !cnt_down && tmr_tick && timer_r == 16'h00FF && !tmr_wr
    |=> timer_r == {8'h00, $past(reload_r[7:0])}) else $error("8-bit mode wrap wrong"); // [R13]
  timer_wr_a: assert property (tmr_wr && pstrb[0] |=> timer_r == $past(pwdata[15:0]))
    else $error("timer write lost"); // [R11]
endmodule

// >>> bench/ccp_field.sv
// Far-side model: capture signal sources and compare pin loads
module ccp_field (
  input wire logic pclk, // Clock
  input wire logic [3:0] cmp_out, // Compare pins
  input wire logic [3:0] cmp_oe, // Pin drive enables
  output logic [1:0] cap_in // Capture sources
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] load_lvl;
  initial cap_in = 2'h0;
  initial load_lvl = 4'h0;
  // Undriven pin has no pull, so the load sees a moving level
  always @(posedge pclk) begin
    load_lvl <= (cmp_oe & cmp_out) | (~cmp_oe & ~load_lvl);
  end
  // Source level changes just after a rising edge
  task automatic drive(input int ch, input logic v);
    @(posedge pclk);
    cap_in[ch] <= v;
  endtask
endmodule

// >>> bench/ccp_unit_tb.sv
// Self-checking testbench of the capture/compare unit
`include "ccp_regs.svh"
module ccp_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, rd;
  logic [3:0] cmp_out, cmp_oe;
  logic [1:0] cap_in;
  logic pready, pslverr, irq, err;
  int failures = 0;
  int n_checks = 0;
  // Clock generator
  always #2.5 pclk = ~pclk;
  ccp_unit dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .cmp_out(cmp_out), .cmp_oe(cmp_oe), .irq(irq));
  ccp_field field_u (.pclk(pclk), .cmp_out(cmp_out), .cmp_oe(cmp_oe), .cap_in(cap_in));
  // Verdict and end of run
  task automatic summarize();
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      failures++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  // Poll FLAGS until bit b is set, bounded
  task automatic wait_flag(input int b, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      rdr(`CCP_OFF_FLAGS);
      if (rd[b] === 1'b1) break;
    end
    if (i == n) begin
      failures++;
      summarize();
    end
  endtask
  // Poll status until the PLL runs, bounded
  task automatic wait_run();
    int i;
    for (i = 0; i < 60; i++) begin
      rdr(`CCP_OFF_STAT);
      if (rd[4:3] === 2'h2) break;
    end
    chk("pll_run", rd[4:3], 2'h2);
  endtask
  // Reset values, unmapped and read-only places
  task automatic t_reset();
    chk("oe_rst", cmp_oe, 4'h0);
    rdr(`CCP_OFF_PRESC);
    chk("presc_rst", rd, 32'h3FF);
    rdr(8'h3C);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped", rd, 32'h0);
    wr(`CCP_OFF_CAPA, 32'hFFFF);
    rdr(`CCP_OFF_CAPA);
    chk("cap_ro", rd, 32'h0);
  endtask
  // Byte pieces through the shadow make one 16-bit value
  task automatic t_shadow();
    apb(1'b1, `CCP_OFF_TIMER, 32'h0000_0034, 4'h1);
    apb(1'b1, `CCP_OFF_TIMER, 32'h0000_12FF, 4'h2);
    rdr(`CCP_OFF_TIMER);
    chk("timer16", rd, 32'h1234);
  endtask
  // Overflow reload, flag, masking and clear
  task automatic t_ovf();
    wr(`CCP_OFF_RELOAD, 32'h1000);
    wr(`CCP_OFF_IEN, 32'h1);
    wr(`CCP_OFF_CTRL, 32'h8);
    wr(`CCP_OFF_TIMER, 32'hFFF0);
    wait_flag(0, 30);
    chk("irq_ovf", irq, 1'b1);
    rdr(`CCP_OFF_TIMER);
    chk("reload", rd >= 32'h1000 && rd < 32'h1040, 1);
    wr(`CCP_OFF_IEN, 32'h0);
    repeat (3) @(posedge pclk);
    chk("irq_mask", irq, 1'b0);
    wr(`CCP_OFF_FLAGS, 32'h1);
    rdr(`CCP_OFF_FLAGS);
    chk("flag_clr", rd[0], 1'b0);
    wr(`CCP_OFF_RELOAD, 32'h0030);
    wr(`CCP_OFF_TIMER, 32'h00F8);
    wr(`CCP_OFF_CTRL, 32'h18);
    wait_flag(0, 20);
    rdr(`CCP_OFF_TIMER);
    chk("narrow", rd >= 32'h30 && rd < 32'h50, 1);
    wr(`CCP_OFF_CTRL, 32'h0);
    wr(`CCP_OFF_TIMER, 32'h0080);
    wr(`CCP_OFF_CTRL, 32'hC);
    repeat (20) @(posedge pclk);
    wr(`CCP_OFF_CTRL, 32'h0);
    rdr(`CCP_OFF_TIMER);
    chk("down", rd < 32'h80 && rd > 32'h50, 1);
  endtask
  // Prescaler ratio of ten
  task automatic t_presc();
    wr(`CCP_OFF_PRESC, 32'h3F6);
    wr(`CCP_OFF_TIMER, 32'h0);
    wr(`CCP_OFF_CTRL, 32'h8);
    repeat (100) @(posedge pclk);
    wr(`CCP_OFF_CTRL, 32'h0);
    rdr(`CCP_OFF_TIMER);
    chk("presc", rd >= 32'd8 && rd <= 32'd12, 1);
    wr(`CCP_OFF_PRESC, 32'h3FF);
  endtask
  // Compare channel A with inverted polarity, B left off
  task automatic t_cmp();
    wr(`CCP_OFF_FLAGS, 32'h7F);
    wr(`CCP_OFF_CMPA, 32'h0020);
    wr(`CCP_OFF_CTRL, 32'h0001_1000);
    repeat (4) @(posedge pclk);
    chk("pol", cmp_out[0], 1'b1);
    chk("oe", cmp_oe, 4'h1);
    wr(`CCP_OFF_TIMER, 32'h0);
    wr(`CCP_OFF_CTRL, 32'h0001_1008);
    wait_flag(3, 30);
    chk("chb_off", rd[4], 1'b0);
    repeat (3) @(posedge pclk);
    chk("toggle", cmp_out[0], 1'b0);
    chk("load_a", field_u.load_lvl[0], 1'b0);
    wr(`CCP_OFF_CTRL, 32'h0);
  endtask
  // PLL lock, asymmetrical and symmetrical counting
  task automatic t_pwm();
    wr(`CCP_OFF_TIMER, 32'h0200);
    wr(`CCP_OFF_CTRL, 32'h309);
    repeat (60) @(posedge pclk);
    rdr(`CCP_OFF_STAT);
    chk("pll_lock", rd[4:3], 2'h1);
    wait_run();
    repeat (20) @(posedge pclk);
    rdr(`CCP_OFF_TIMER);
    chk("asym", rd < 32'h200 && rd > 32'h1C0, 1);
    wr(`CCP_OFF_CTRL, 32'h0030_0329);
    wr(`CCP_OFF_CTRL, 32'h0030_3329);
    rdr(`CCP_OFF_STAT);
    chk("alt_gate", cmp_out[1:0], rd[2] ? 2'h2 : 2'h1);
    wr(`CCP_OFF_RELOAD, 32'h0210);
    wr(`CCP_OFF_CTRL, 32'h30A);
    wait_run();
    wr(`CCP_OFF_TIMER, 32'h0200);
    repeat (40) @(posedge pclk);
    rdr(`CCP_OFF_TIMER);
    chk("sym", rd < 32'h210 && rd > 32'h1D0, 1);
    wr(`CCP_OFF_CTRL, 32'h0);
  endtask
  // Capture edges, glitch filter and event counter
  task automatic t_cap();
    wr(`CCP_OFF_FLAGS, 32'h7F);
    wr(`CCP_OFF_TIMER, 32'h0ABC);
    wr(`CCP_OFF_EVCNT, 32'h10);
    wr(`CCP_OFF_CTRL, 32'h0A00_0000);
    field_u.drive(0, 1'b1);
    repeat (8) @(posedge pclk);
    rdr(`CCP_OFF_CAPA);
    chk("capa", rd, 32'h0ABC);
    field_u.drive(1, 1'b1);
    repeat (8) @(posedge pclk);
    field_u.drive(1, 1'b0);
    repeat (2) @(posedge pclk);
    field_u.drive(1, 1'b1);
    repeat (8) @(posedge pclk);
    wr(`CCP_OFF_TIMER, 32'h0111);
    field_u.drive(1, 1'b0);
    repeat (8) @(posedge pclk);
    rdr(`CCP_OFF_FLAGS);
    chk("flags_c", rd[2:1], 2'h1);
    field_u.drive(1, 1'b1);
    repeat (8) @(posedge pclk);
    wr(`CCP_OFF_TIMER, 32'h0222);
    field_u.drive(1, 1'b0);
    repeat (8) @(posedge pclk);
    rdr(`CCP_OFF_CAPB);
    chk("capb", rd, 32'h0222);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_shadow();
    t_ovf();
    t_presc();
    t_cmp();
    t_pwm();
    t_cap();
    summarize();
  end
endmodule
